// [pkg/mpf_cfg.svh]
// constants of the pin function router: register indices, reset values,
// bus answers; included by the package user files, definitions only
`ifndef MPF_CFG_SVH
`define MPF_CFG_SVH

// ****************************************
// register indices (byte address = 4 x index)
// ****************************************
`define MPF_IDX_DIR    8'h60
`define MPF_IDX_SEL0   8'h61
`define MPF_IDX_SEL1   8'h62
`define MPF_IDX_SEL2   8'h63
`define MPF_IDX_ROUTE  8'h64
`define MPF_IDX_OUTV   8'h65
`define MPF_IDX_INV    8'h66
`define MPF_IDX_DIE    8'h67

// ****************************************
// widths, reset values, answers
// ****************************************
`define MPF_ADDR_LSB   2
`define MPF_IDX_W      8
`define MPF_REG_RST    8'h00
`define MPF_BIT_RST    1'b0
// arbitrary value, names no real part
`define MPF_SILICON_REVISION_CODE_DEF 8'h5A
`define MPF_RESP_OKAY  2'h0
`define MPF_RESP_ERR   2'h2
// level that an unrouted active-low input rests at
`define MPF_IDLE_LOW_N 1'b1

`endif

// [pkg/mpf_pkg.sv]
// types of the pin function router: selector codes, routing codes,
// register layouts and signal groups; no logic
package mpf_pkg;

  typedef enum logic [3:0] {
    MPF_SEL_LOW       = 4'h0,
    MPF_SEL_RSV1      = 4'h1,
    MPF_SEL_USER      = 4'h2,
    MPF_SEL_MUTE_BOTH = 4'h3,
    MPF_SEL_MUTE_L    = 4'h4,
    MPF_SEL_MUTE_R    = 4'h5,
    MPF_SEL_CLK_BAD   = 4'h6,
    MPF_SEL_RSV7      = 4'h7,
    MPF_SEL_WARN      = 4'h8,
    MPF_SEL_SER_OUT   = 4'h9,
    MPF_SEL_RSVA      = 4'hA,
    MPF_SEL_FAULT     = 4'hB,
    MPF_SEL_SPI_CLK   = 4'hC,
    MPF_SEL_SPI_MOSI  = 4'hD,
    MPF_SEL_RSVE      = 4'hE,
    MPF_SEL_RSVF      = 4'hF
  } mpf_sel_e;

  typedef enum logic [1:0] {
    MPF_SRC_NONE = 2'h0,
    MPF_SRC_PIN0 = 2'h1,
    MPF_SRC_PIN1 = 2'h2,
    MPF_SRC_PIN2 = 2'h3
  } mpf_route_e;

  typedef struct packed {
    logic [3:0] rsv;
    mpf_sel_e   code;
  } mpf_sel_t;

  typedef struct packed {
    mpf_route_e miso;
    mpf_route_e ramp_sync_source;
    mpf_route_e reset_source;
    mpf_route_e mute_source;
  } mpf_route_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic [2:0] bits;
  } mpf_pinbits_t;

  typedef struct packed {
    mpf_pinbits_t   dir;
    mpf_sel_t [2:0] sel;
    mpf_route_t     route;
    mpf_pinbits_t   outv;
    mpf_pinbits_t   inv;
  } mpf_regs_t;

  // device signals offered to the pins
  typedef struct packed {
    logic automute_l;
    logic automute_r;
    logic clock_invalid;
    logic warning_low_output;
    logic fault_low_output;
    logic serial_audio_out;
    logic spi_clk;
    logic spi_mosi;
  } mpf_src_t;

  // device inputs taken from the pins
  typedef struct packed {
    logic spi_miso;
    logic ramp_sync;
    logic reset_low;
    logic mute_low_input;
    logic amp_hiz;
  } mpf_rin_t;

  typedef struct packed {
    logic out;
    logic oe;
  } mpf_pin_t;

endpackage

// [design/mpf_pin_mux.sv]
// one pin's output path: function selector, inversion, output enable
// assumes selector and sources are synchronous to mclk
`timescale 1ns/1ns
`include "mpf_cfg.svh"

module mpf_pin_mux (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire mpf_pkg::mpf_sel_e code,
  input  wire logic              user_bit,
  input  wire logic              invert,
  input  wire logic              enable,
  input  wire mpf_pkg::mpf_src_t src,
  output logic                   pin_out,
  output logic                   pin_oe
);

  mpf_pkg::mpf_pin_t s;
  mpf_pkg::mpf_pin_t next_s;
  logic              raw;

  // ****************************************
  // selector decode
  // ****************************************
  always_comb begin
    case (code)
      mpf_pkg::MPF_SEL_LOW:       raw = 1'b0;
      mpf_pkg::MPF_SEL_USER:      raw = user_bit;
      mpf_pkg::MPF_SEL_MUTE_BOTH: begin
        raw = src.automute_l & src.automute_r;
      end
      mpf_pkg::MPF_SEL_MUTE_L:    raw = src.automute_l;
      mpf_pkg::MPF_SEL_MUTE_R:    raw = src.automute_r;
      mpf_pkg::MPF_SEL_CLK_BAD:   raw = src.clock_invalid;
      mpf_pkg::MPF_SEL_WARN:      raw = src.warning_low_output;
      mpf_pkg::MPF_SEL_SER_OUT:   raw = src.serial_audio_out;
      mpf_pkg::MPF_SEL_FAULT:     raw = src.fault_low_output;
      mpf_pkg::MPF_SEL_SPI_CLK:   raw = src.spi_clk;
      mpf_pkg::MPF_SEL_SPI_MOSI:  raw = src.spi_mosi;
      // reserved codes park low, then inversion applies
      default:                    raw = 1'b0;
    endcase
    next_s.out = raw ^ invert;
    next_s.oe  = enable;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '{out: `MPF_BIT_RST, oe: `MPF_BIT_RST};
    end else begin
      s <= next_s;
    end
  end

  assign pin_out = s.out;
  assign pin_oe  = s.oe;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_reserved_low;
    (code == mpf_pkg::MPF_SEL_RSVA) |=> (pin_out == $past(invert));
  endproperty
  a_reserved_low: assert property (p_reserved_low)
    else $error("reserved code did not park the pin");

  property p_warn_route;
    (code == mpf_pkg::MPF_SEL_WARN) && !invert
      |=> (pin_out == $past(src.warning_low_output));
  endproperty
  a_warn_route: assert property (p_warn_route)
    else $error("warning output not on pin");

endmodule

// [design/mpf_router.sv]
// pin function router: AXI4-Lite register file, three pin output paths,
// input routing for miso, ramp sync, reset and mute
// assumes pin inputs and device signals are synchronous to mclk
// What this block does
// - selector code 0000 drives the pin low and 0010 drives the user bit.
// - code 0011 drives a flag high only while both channels auto mute.
// - codes 0100 and 0101 drive the left and right auto-mute flags.
// - code 0110 drives the clock-invalid flag.
// - code 1000 makes the pin the active-low warning output.
// - code 1001 puts the serial audio data out stream on the pin.
// - code 1011 makes the pin the active-low fault output.
// - codes 1100 and 1101 put the spi clock and spi mosi on the pin.
// - miso and ramp sync fields pick none, pin 0, pin 1 or pin 2.
// - reset field picks the reset pin; pin 2 keeps its setup only when pin 2 is that reset pin.
// - the mute field picks an active-low mute pin that idles the amp.
// - the user output register holds one value bit per pin.
// - the inversion register holds one bit per pin that flips it.
// - the direction register enables each pin as an output when set.
`timescale 1ns/1ns
`include "mpf_cfg.svh"

module mpf_router #(
  parameter int         AW     = 12,
  // arbitrary value, names no real part
  parameter logic [7:0] SILICON_REVISION_CODE = `MPF_SILICON_REVISION_CODE_DEF
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [AW-1:0]     s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AW-1:0]     s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [2:0]        pin_in,
  output logic [2:0]             pin_out,
  output logic [2:0]             pin_oe,
  input  wire mpf_pkg::mpf_src_t src,
  output mpf_pkg::mpf_rin_t      routed
);

  typedef struct packed {
    mpf_pkg::mpf_regs_t r;
    logic               aw_got;
    logic               aw_hit;
    logic [7:0]         aw_idx;
    logic               w_got;
    logic [7:0]         w_data;
    logic               w_en;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [7:0]         rdata;
    logic [1:0]         rresp;
    mpf_pkg::mpf_rin_t  rin;
  } mpf_state_t;

  mpf_state_t      s;
  mpf_state_t      next_s;
  logic            aw_fire;
  logic            w_fire;
  logic            ar_fire;
  logic            wr_now;
  logic [AW-3:0]   aw_word;
  logic [AW-3:0]   ar_word;
  logic [8:0]      rd_res;
  logic [8:0]      wr_res;
  logic            pin_rst_n;
  logic            mute_n;

  // ****************************************
  // register read decode
  // ****************************************
  // returns {hit, data}
  function automatic logic [8:0] rd_reg(mpf_pkg::mpf_regs_t r,
                                        logic [7:0] idx);
    logic [8:0] v;
    v = {1'b1, `MPF_REG_RST};
    case (idx)
      `MPF_IDX_DIR:   v[7:0] = r.dir;
      `MPF_IDX_SEL0:  v[7:0] = r.sel[0];
      `MPF_IDX_SEL1:  v[7:0] = r.sel[1];
      `MPF_IDX_SEL2:  v[7:0] = r.sel[2];
      `MPF_IDX_ROUTE: v[7:0] = r.route;
      `MPF_IDX_OUTV:  v[7:0] = r.outv;
      `MPF_IDX_INV:   v[7:0] = r.inv;
      `MPF_IDX_DIE:   v[7:0] = SILICON_REVISION_CODE;
      default:        v[8]   = 1'b0;
    endcase
    return v;
  endfunction

  // picks the pin named by a routing code, idle level when none
  function automatic logic pick(mpf_pkg::mpf_route_e code,
                                logic [2:0] pins, logic idle);
    logic v;
    case (code)
      mpf_pkg::MPF_SRC_PIN0: v = pins[0];
      mpf_pkg::MPF_SRC_PIN1: v = pins[1];
      mpf_pkg::MPF_SRC_PIN2: v = pins[2];
      default:               v = idle;
    endcase
    return v;
  endfunction

  // ****************************************
  // bus handshakes
  // ****************************************
  // one write and one read in flight; address and data in either order
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire  = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign wr_now  = s.aw_got && s.w_got && !s.bvalid;
  assign aw_word = s_axi_awaddr[AW-1:`MPF_ADDR_LSB];
  assign ar_word = s_axi_araddr[AW-1:`MPF_ADDR_LSB];
  assign rd_res  = rd_reg(s.r, ar_word[7:0]);
  assign wr_res  = rd_reg(s.r, s.aw_idx);

  assign pin_rst_n = pick(s.r.route.reset_source, pin_in,
                          `MPF_IDLE_LOW_N);
  assign mute_n    = pick(s.r.route.mute_source, pin_in,
                          `MPF_IDLE_LOW_N);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    if (aw_fire) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = aw_word[7:0];
      next_s.aw_hit = (aw_word[AW-3:`MPF_IDX_W] == '0);
    end
    if (w_fire) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata[7:0];
      next_s.w_en   = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_now) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `MPF_RESP_OKAY;
      // upper lanes carry nothing; the id register ignores writes
      if (!s.aw_hit || !wr_res[8]) begin
        next_s.bresp = `MPF_RESP_ERR;
      end else if (s.w_en) begin
        case (s.aw_idx)
          `MPF_IDX_DIR:   next_s.r.dir     = s.w_data;
          `MPF_IDX_SEL0:  next_s.r.sel[0]  = s.w_data;
          `MPF_IDX_SEL1:  next_s.r.sel[1]  = s.w_data;
          `MPF_IDX_SEL2:  next_s.r.sel[2]  = s.w_data;
          `MPF_IDX_ROUTE: next_s.r.route   = s.w_data;
          `MPF_IDX_OUTV:  next_s.r.outv    = s.w_data;
          `MPF_IDX_INV:   next_s.r.inv     = s.w_data;
          default:        next_s.r         = s.r;
        endcase
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_res[7:0];
      next_s.rresp  = `MPF_RESP_OKAY;
      if (!rd_res[8] || (ar_word[AW-3:`MPF_IDX_W] != '0)) begin
        next_s.rdata = `MPF_REG_RST;
        next_s.rresp = `MPF_RESP_ERR;
      end
    end
    // pin reset wins over a bus write; routing itself is kept
    if (!pin_rst_n) begin
      for (int i = 0; i < 3; i++) begin
        if (!(i == 2 &&
              s.r.route.reset_source == mpf_pkg::MPF_SRC_PIN2)) begin
          next_s.r.dir.bits[i]  = `MPF_BIT_RST;
          next_s.r.outv.bits[i] = `MPF_BIT_RST;
          next_s.r.inv.bits[i]  = `MPF_BIT_RST;
          next_s.r.sel[i]       = `MPF_REG_RST;
        end
      end
    end
    next_s.rin.spi_miso  = pick(s.r.route.miso, pin_in,
                                `MPF_BIT_RST);
    next_s.rin.ramp_sync = pick(s.r.route.ramp_sync_source, pin_in,
                                `MPF_BIT_RST);
    next_s.rin.reset_low      = pin_rst_n;
    next_s.rin.mute_low_input = mute_n;
    next_s.rin.amp_hiz        = !mute_n;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s     <= '0;
      s.rin <= '{spi_miso: `MPF_BIT_RST, ramp_sync: `MPF_BIT_RST,
                 reset_low: `MPF_IDLE_LOW_N,
                 mute_low_input: `MPF_IDLE_LOW_N,
                 amp_hiz: `MPF_BIT_RST};
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp  = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp  = s.rresp;
  assign s_axi_rdata  = {24'h000000, s.rdata};
  assign routed       = s.rin;

  // ****************************************
  // pin output paths
  // ****************************************
  for (genvar g = 0; g < 3; g++) begin : g_pin
    mpf_pin_mux u_mux (
      .mclk     (mclk),
      .rst      (rst),
      .code     (s.r.sel[g].code),
      .user_bit (s.r.outv.bits[g]),
      .invert   (s.r.inv.bits[g]),
      .enable   (s.r.dir.bits[g]),
      .src      (src),
      .pin_out  (pin_out[g]),
      .pin_oe   (pin_oe[g])
    );
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_user_value;
    (s.r.sel[1].code == mpf_pkg::MPF_SEL_USER)
      |=> (pin_out[1] == ($past(s.r.outv.bits[1]) ^ $past(s.r.inv.bits[1])));
  endproperty
  a_user_value: assert property (p_user_value)
    else $error("pin 1 does not follow the user bit");

  property p_mute_both;
    (s.r.sel[2].code == mpf_pkg::MPF_SEL_MUTE_BOTH) && !s.r.inv.bits[2]
      |=> (pin_out[2] == $past(src.automute_l && src.automute_r));
  endproperty
  a_mute_both: assert property (p_mute_both)
    else $error("combined auto-mute flag wrong");

  property p_mute_left;
    (s.r.sel[1].code == mpf_pkg::MPF_SEL_MUTE_L) && !s.r.inv.bits[1]
      |=> (pin_out[1] == $past(src.automute_l));
  endproperty
  a_mute_left: assert property (p_mute_left)
    else $error("left auto-mute flag not on pin 1");

  property p_clk_bad;
    (s.r.sel[2].code == mpf_pkg::MPF_SEL_CLK_BAD) && s.r.inv.bits[2]
      |=> (pin_out[2] == !$past(src.clock_invalid));
  endproperty
  a_clk_bad: assert property (p_clk_bad)
    else $error("clock-invalid flag not on pin 2");

  property p_spi_clk;
    (s.r.sel[1].code == mpf_pkg::MPF_SEL_SPI_CLK) && !s.r.inv.bits[1]
      |=> (pin_out[1] == $past(src.spi_clk));
  endproperty
  a_spi_clk: assert property (p_spi_clk)
    else $error("spi clock not on pin 1");

  property p_miso_route;
    (s.r.route.miso == mpf_pkg::MPF_SRC_PIN1)
      |=> (routed.spi_miso == $past(pin_in[1]));
  endproperty
  a_miso_route: assert property (p_miso_route)
    else $error("miso not taken from pin 1");

  property p_pin2_kept;
    (s.r.route.reset_source == mpf_pkg::MPF_SRC_PIN2) && !pin_in[2]
      && !wr_now
      |=> (s.r.dir.bits[2] == $past(s.r.dir.bits[2])) && !s.r.dir.bits[1];
  endproperty
  a_pin2_kept: assert property (p_pin2_kept)
    else $error("pin reset handling wrong");

  property p_mute_hiz;
    (s.r.route.mute_source == mpf_pkg::MPF_SRC_PIN0) && !pin_in[0]
      |=> routed.amp_hiz && !routed.mute_low_input;
  endproperty
  a_mute_hiz: assert property (p_mute_hiz)
    else $error("mute pin did not idle the amplifier");

  sequence s_outv_write;
    aw_fire && w_fire && s_axi_wstrb[0]
      && (s_axi_awaddr[AW-1:`MPF_ADDR_LSB] == `MPF_IDX_OUTV);
  endsequence
  property p_outv_store;
    s_outv_write ##1 pin_rst_n
      |=> (s.r.outv.bits == $past(s_axi_wdata[2:0], 2)) && s.bvalid;
  endproperty
  a_outv_store: assert property (p_outv_store)
    else $error("user output register not stored");

  property p_invert_low;
    (s.r.sel[0].code == mpf_pkg::MPF_SEL_LOW) && s.r.inv.bits[0]
      |=> pin_out[0];
  endproperty
  a_invert_low: assert property (p_invert_low)
    else $error("inversion not applied after forced low");

  property p_dir;
    1'b1 |=> (pin_oe == $past(s.r.dir.bits));
  endproperty
  a_dir: assert property (p_dir)
    else $error("output enable does not follow direction");

endmodule

// [tb/mpf_board.sv]
// board model: the far side of the three pins
// assumes the bench sets the level each pin is driven to from outside
`timescale 1ns/1ns

module mpf_board (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] ext_level,
  output logic      [2:0] pin_in
);
  // ****************************************
  // pin wire resolution
  // ****************************************
  // the device wins while enabled, else the board level shows
  always_comb begin
    for (int n = 0; n < 3; n++) begin
      pin_in[n] = pin_oe[n] ? pin_out[n] : ext_level[n];
    end
  end
endmodule

// [tb/tb_mpf_router.sv]
// self-checking bench of the pin function router
// assumes the board model closes the loop from pin drive to pin level
`timescale 1ns/1ns
`include "mpf_cfg.svh"

module tb_mpf_router;
  // arbitrary value, names no real part
  localparam logic [7:0] DIE = 8'h3C;
  localparam logic [1:0] OK  = `MPF_RESP_OKAY;
  logic              mclk, rst;
  logic [11:0]       awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [2:0]        pin_in, pin_out, pin_oe, ext, u, iv;
  logic [3:0]        c1, c2;
  logic [7:0]        e8;
  logic [1:0]        v;
  mpf_pkg::mpf_src_t src;
  mpf_pkg::mpf_rin_t routed;
  logic [33:0]       q_bus[$];
  int                errors, n_compared, seed;
  // reserved 0001, 0111 and 1110 never written
  logic [3:0] codes[13] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8,
                            4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};

  mpf_router #(.AW(12), .SILICON_REVISION_CODE(DIE)) dut (
    .mclk(mclk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .src(src), .routed(routed)
  );

  mpf_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
                   .pin_in(pin_in));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // compare and report
  // ****************************************
  task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // answers are judged in the cycle of their handshake
  always @(posedge mclk) begin
    if (bvalid && bready)
      cmp_bus({bresp, 32'h0}, q_bus.pop_front());
    if (rvalid && rready)
      cmp_bus({rresp, rdata}, q_bus.pop_front());
  end

  // ****************************************
  // bus master
  // ****************************************
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] r);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    q_bus.push_back({r, 32'h0});
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(a && w)) begin
      @(posedge mclk);
      if (!a && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge mclk);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [33:0] e);
    q_bus.push_back(e);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge mclk);
    while (!arready) @(posedge mclk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge mclk);
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  function automatic logic pexp(input logic [3:0] c, input logic u_b,
                                input logic i_b);
    logic x;
    case (c)
      4'h2: x = u_b;
      4'h3: x = src.automute_l & src.automute_r;
      4'h4: x = src.automute_l;
      4'h5: x = src.automute_r;
      4'h6: x = src.clock_invalid;
      4'h8: x = src.warning_low_output;
      4'h9: x = src.serial_audio_out;
      4'hB: x = src.fault_low_output;
      4'hC: x = src.spi_clk;
      4'hD: x = src.spi_mosi;
      default: x = 1'b0;
    endcase
    return x ^ i_b;
  endfunction

  // unrouted inputs rest at their default level
  function automatic logic pk(input logic [1:0] s, input logic dflt);
    return (s == 2'h0) ? dflt : ext[s - 2'h1];
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, src} = '0;
    ext = 3'b111;
    seed = 32'h3F0D;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 7; i++)
      rd(`MPF_IDX_DIR + 8'(i), 34'h0);
    rd(`MPF_IDX_DIE, {OK, 24'h0, DIE});
    wr(`MPF_IDX_DIE, 8'hFF, OK);
    rd(`MPF_IDX_DIE, {OK, 24'h0, DIE});
    wr(8'h68, 8'h11, `MPF_RESP_ERR);
    rd(8'h68, {`MPF_RESP_ERR, 32'h0});
    wr(`MPF_IDX_INV, 8'hF8, OK);
    rd(`MPF_IDX_INV, {OK, 24'h0, 8'hF8});
    wr(`MPF_IDX_DIR, 8'h06, OK);
    for (int k = 0; k < 26; k++) begin
      c1 = codes[k % 13];
      c2 = codes[{$random(seed)} % 13];
      u = 3'($random(seed));
      iv = 3'($random(seed));
      src <= 8'($random(seed));
      wr(`MPF_IDX_SEL1, {4'h0, c1}, OK);
      wr(`MPF_IDX_SEL2, {4'h0, c2}, OK);
      wr(`MPF_IDX_OUTV, {5'h0, u}, OK);
      wr(`MPF_IDX_INV, {5'h0, iv}, OK);
      repeat (2) @(posedge mclk);
      // pin 0 stays on forced low, so only its inversion shows
      e8 = {3'b110, pexp(c2, u[2], iv[2]), pexp(c1, u[1], iv[1]), iv[0],
            2'b00};
      cmp_pin({pin_oe, pin_out, 2'b00}, e8);
    end
    wr(`MPF_IDX_DIR, 8'h00, OK);
    for (int s = 0; s < 4; s++) begin
      v = 2'(s);
      ext <= 3'($random(seed));
      wr(`MPF_IDX_ROUTE, {v, v, v, v}, OK);
      repeat (3) @(posedge mclk);
      e8 = {3'b000, pk(v, 1'b0), pk(v, 1'b0), pk(v, 1'b1), pk(v, 1'b1),
            !pk(v, 1'b1)};
      cmp_pin({3'b000, routed}, e8);
    end
    // pin reset from pin 2 spares pin 2's own setup
    ext <= 3'b111;
    wr(`MPF_IDX_ROUTE, 8'h0C, OK);
    wr(`MPF_IDX_SEL1, 8'h02, OK);
    wr(`MPF_IDX_SEL2, 8'h03, OK);
    wr(`MPF_IDX_OUTV, 8'h07, OK);
    ext <= 3'b011;
    repeat (3) @(posedge mclk);
    ext <= 3'b111;
    repeat (2) @(posedge mclk);
    rd(`MPF_IDX_SEL1, 34'h0);
    rd(`MPF_IDX_SEL2, {OK, 24'h0, 8'h03});
    rd(`MPF_IDX_OUTV, {OK, 24'h0, 8'h04});
    rd(`MPF_IDX_ROUTE, {OK, 24'h0, 8'h0C});
    wr(`MPF_IDX_ROUTE, 8'h04, OK);
    ext <= 3'b110;
    repeat (3) @(posedge mclk);
    ext <= 3'b111;
    repeat (2) @(posedge mclk);
    rd(`MPF_IDX_SEL2, 34'h0);
    results();
  end

  // whole run is some six hundred cycles
  initial begin
    repeat (6000) @(posedge mclk);
    errors++;
    results();
  end
endmodule
